// ### bccc_battery_model.sv
// battery pack model facing the charge sequencer
// assumes the bench sets the pack level and reads nothing back
`timescale 1ns/100ps
`default_nettype none
module bccc_battery_model
    import bccc_pkg::*;
(
    // pack state
    input  wire logic [FB_W-1:0]  level,
    // charger outputs
    input  wire logic [2:0]       chargePhase,
    input  wire logic [LIM_W-1:0] currentTarget,
    // measurements
    output logic      [FB_W-1:0]  feedbackLevel,
    output logic      [LIM_W-1:0] chargeCurrent
);
    // ------------------------------------------------------------
    // pack response
    // ------------------------------------------------------------
    assign feedbackLevel = level;
    // current tapers to one step once the pack is full
    always_comb begin
        if (chargePhase == PH_IDLE || chargePhase == PH_DONE) begin
            chargeCurrent = 9'h000;
        end else if (level >= FB_TARGET) begin
            chargeCurrent = 9'h001;
        end else begin
            chargeCurrent = currentTarget;
        end
    end
endmodule // bccc_battery_model
`default_nettype wire

// ### bccc_charge_ctrl.sv
// charge cycle sequencer with apb registers and current limit logic
// assumes synchronous digital inputs: feedback in mV, currents in 50 mA codes
//
// Contract
// - enabled device runs whole cycle alone
// - start needs input, no hiz, bias, enable, no faults
// - terminate: low current, high voltage, no regulation
// - discharge below recharge field restarts cycle
// - enable toggle after completion restarts charging
// - phase reported as three bit code
// - alert pulse on every phase change
// - trickle below short, precharge below low
// - cleared precharge bit skips trickle, precharge
// - without precharge, full current below target
// - limit is lower of pin and register
// - precharge twenty, termination ten percent pin
// - pin above reference enters current regulation
// - grounded pin leaves register limit alone
// - pin disable bit ignores pin entirely
// - register codes 400 to 20000 mA
// - register resets to maximum code
// - target 1.536 V, low 66.7%, recharge 97.6%
// - cycle start picks phase from voltage
// - regulation suspends termination, halves timer rate
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module bccc_charge_ctrl
    import bccc_pkg::*;
#(
    parameter longint unsigned SAFETY_LIMIT = SAFETY_CYCLES
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic      [31:0]      prdata,
    // start qualification and input limit flag
    input  wire logic             inputWindowOk,
    input  wire logic             hizPin,
    input  wire logic             biasGood,
    input  wire logic             chargeEnablePin_n,
    input  wire logic             thermFault,
    input  wire logic             inputLimitActive,
    // battery measurements
    input  wire logic [FB_W-1:0]  feedbackLevel,
    input  wire logic [LIM_W-1:0] chargeCurrent,
    // current limit pin
    input  wire logic [LIM_W-1:0] pinLimit,
    input  wire logic             pinGrounded,
    input  wire logic             pinAboveRef,
    // charge status and targets
    output logic      [2:0]       chargePhase,
    output logic                  hostAlert,
    output logic                  timerFault,
    output logic      [LIM_W-1:0] chargeLimit,
    output logic      [LIM_W-1:0] prechargeLimit,
    output logic      [LIM_W-1:0] termLimit,
    output logic      [LIM_W-1:0] currentTarget,
    output logic                  currentRegulating,
    output logic                  pinMonitorActive
);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [LIM_W-1:0]  limitReg;
        logic [31:0]       rdata;
        bccc_phase_t       phase;
        logic              finished;
        logic              enPrev;
        logic              alert;
        logic [LIM_W-1:0]  limit;
        logic [LIM_W-1:0]  preLimit;
        logic [LIM_W-1:0]  termLim;
        logic [LIM_W-1:0]  target;
        logic              regulating;
        logic              monitor;
    } bccc_state_t;

    localparam logic [11:0] FB_LOWV  = bccc_fb_pm(PM_LOWV);
    localparam logic [11:0] FB_SHORT = bccc_fb_pm(PM_SHORT);

    bccc_state_t cur;
    bccc_state_t next_cur;

    logic             chargeOn;
    logic             enRise;
    logic             startOk;
    logic             pinUse;
    logic             tmrExpired;
    logic             tmrClear;
    logic             tmrRun;
    logic [FB_W-1:0]  rechargeLevel;
    logic [LIM_W-1:0] wrLimit;
    logic             mapped;
    logic             setupPhase;
    logic             writeAccess;

    // ------------------------------------------------------------
    // qualification and threshold selection
    // ------------------------------------------------------------
    assign chargeOn = cur.ctrl[CTRL_CHG_EN] && !chargeEnablePin_n;
    assign enRise   = chargeOn && !cur.enPrev;
    assign startOk  = inputWindowOk && !hizPin && !cur.ctrl[CTRL_HIZ] && biasGood
                      && chargeOn && !thermFault && !tmrExpired;
    assign pinUse   = cur.ctrl[CTRL_PIN_EN] && !pinGrounded;

    always_comb begin
        case (cur.ctrl[CTRL_RCH_LO +: 2])
            2'b00:   rechargeLevel = bccc_fb_pm(PM_RCH0);
            2'b01:   rechargeLevel = bccc_fb_pm(PM_RCH1);
            2'b10:   rechargeLevel = bccc_fb_pm(PM_RCH2);
            default: rechargeLevel = bccc_fb_pm(PM_RCH3);
        endcase
    end

    // clamp written code to legal range
    always_comb begin
        wrLimit = pwdata[LIM_W-1:0];
        if (pwdata[LIM_W-1:0] < LIM_MIN) begin
            wrLimit = LIM_MIN;
        end else if (pwdata[LIM_W-1:0] > LIM_MAX || pwdata[31:LIM_W] != '0) begin
            wrLimit = LIM_MAX;
        end
    end

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    assign mapped      = (paddr == ADDR_CTRL) || (paddr == ADDR_LIMIT) || (paddr == ADDR_STATUS);
    assign setupPhase  = psel && !penable;
    assign writeAccess = psel && penable && pwrite && mapped;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && !mapped;

    // ------------------------------------------------------------
    // safety timer
    // ------------------------------------------------------------
    assign tmrClear = enRise || (cur.phase == PH_DONE);
    assign tmrRun   = cur.ctrl[CTRL_TMR_EN] && startOk
                      && (cur.phase != PH_IDLE) && (cur.phase != PH_DONE);

    bccc_safety_timer #(
        .LIMIT    (SAFETY_LIMIT)
    ) u_timer (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .clear    (tmrClear),
        .run      (tmrRun),
        .halfRate (inputLimitActive),
        .expired  (tmrExpired)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur        = cur;
        next_cur.enPrev = chargeOn;

        if (setupPhase) begin
            case (paddr)
                ADDR_CTRL:   next_cur.rdata = 32'(cur.ctrl);
                ADDR_LIMIT:  next_cur.rdata = 32'(cur.limitReg);
                ADDR_STATUS: next_cur.rdata = {23'h00_0000, cur.monitor, cur.regulating,
                                               cur.finished, tmrExpired, startOk,
                                               1'b0, cur.phase};
                default:     next_cur.rdata = 32'h0000_0000;
            endcase
        end
        if (writeAccess && paddr == ADDR_CTRL) begin
            next_cur.ctrl = pwdata[CTRL_W-1:0];
        end
        if (writeAccess && paddr == ADDR_LIMIT) begin
            next_cur.limitReg = wrLimit;
        end

        if (enRise) begin
            next_cur.finished = 1'b0;
        end

        case (cur.phase)
            PH_IDLE: begin
                if (cur.finished && feedbackLevel < rechargeLevel) begin
                    next_cur.finished = 1'b0;
                end
                if (startOk && (!cur.finished || enRise)) begin
                    if (cur.ctrl[CTRL_PRE_EN] && feedbackLevel < FB_SHORT) begin
                        next_cur.phase = PH_TRICKLE;
                    end else if (cur.ctrl[CTRL_PRE_EN] && feedbackLevel < FB_LOWV) begin
                        next_cur.phase = PH_PRE;
                    end else if (feedbackLevel < FB_TARGET) begin
                        next_cur.phase = PH_CC;
                    end else begin
                        next_cur.phase = PH_CV;
                    end
                end
            end
            PH_TRICKLE: begin
                if (!cur.ctrl[CTRL_PRE_EN]) begin
                    next_cur.phase = PH_CC;
                end else if (feedbackLevel >= FB_SHORT) begin
                    next_cur.phase = PH_PRE;
                end
            end
            PH_PRE: begin
                if (!cur.ctrl[CTRL_PRE_EN] || feedbackLevel >= FB_LOWV) begin
                    next_cur.phase = PH_CC;
                end
            end
            PH_CC: begin
                if (feedbackLevel >= FB_TARGET) begin
                    next_cur.phase = PH_CV;
                end
            end
            PH_CV: begin
                if (cur.ctrl[CTRL_TERM_EN] && chargeCurrent < cur.termLim
                    && feedbackLevel > rechargeLevel && !inputLimitActive) begin
                    next_cur.phase    = PH_DONE;
                    next_cur.finished = 1'b1;
                end
            end
            PH_DONE: begin
                if (feedbackLevel < rechargeLevel) begin
                    next_cur.phase    = PH_IDLE;
                    next_cur.finished = 1'b0;
                end
            end
            default: next_cur.phase = PH_IDLE;
        endcase

        if (!startOk && cur.phase != PH_DONE) begin
            next_cur.phase = PH_IDLE;
        end else if (!startOk) begin
            next_cur.phase = PH_IDLE;
        end

        next_cur.alert = (next_cur.phase != cur.phase);

        if (pinUse && pinLimit < cur.limitReg) begin
            next_cur.limit = pinLimit;
        end else begin
            next_cur.limit = cur.limitReg;
        end
        next_cur.preLimit   = bccc_pct(pinUse ? pinLimit : cur.limitReg, PCT_PRE);
        next_cur.termLim    = bccc_pct(pinUse ? pinLimit : cur.limitReg, PCT_TERM);
        next_cur.regulating = pinUse && pinAboveRef;
        next_cur.monitor    = pinUse && !pinAboveRef;

        case (next_cur.phase)
            PH_TRICKLE, PH_PRE: next_cur.target = next_cur.preLimit;
            PH_CC, PH_CV:       next_cur.target = next_cur.limit;
            default:            next_cur.target = '0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur          <= '0;
            cur.ctrl     <= CTRL_RESET;
            cur.limitReg <= LIM_MAX;
            cur.limit    <= LIM_MAX;
            cur.phase    <= PH_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // phase code
    assign chargePhase       = cur.phase;
    assign hostAlert         = cur.alert;
    assign timerFault        = tmrExpired;
    assign chargeLimit       = cur.limit;
    assign prechargeLimit    = cur.preLimit;
    assign termLimit         = cur.termLim;
    assign currentTarget     = cur.target;
    assign currentRegulating = cur.regulating;
    assign pinMonitorActive  = cur.monitor;
    assign prdata            = cur.rdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_toggle;
        !chargeOn ##1 (chargeOn && startOk && cur.phase == PH_IDLE);
    endsequence

    sequence s_drained;
        (cur.phase == PH_DONE) && (feedbackLevel < rechargeLevel) && startOk;
    endsequence

    chk_alert_phase: assert property (
        hostAlert == (chargePhase != $past(chargePhase))
    ) else $error("alert does not match phase change");

    chk_idle_blocked: assert property (
        !startOk |=> chargePhase == PH_IDLE
    ) else $error("phase not idle after lost start condition");

    chk_term_cause: assert property (
        $rose(chargePhase == PH_DONE) |-> $past(!inputLimitActive && chargeCurrent < termLimit)
    ) else $error("termination without its conditions");

    chk_limit_lower: assert property (
        $past(rst_n) |-> (chargeLimit <= $past(cur.limitReg)) && (!$past(pinUse) || chargeLimit <= $past(pinLimit))
    ) else $error("charge limit above a source limit");

    chk_limit_range: assert property (
        cur.limitReg >= LIM_MIN && cur.limitReg <= LIM_MAX
    ) else $error("charge current code out of range");

    chk_skip_pre: assert property (
        !cur.ctrl[CTRL_PRE_EN] |=> chargePhase != PH_TRICKLE && chargePhase != PH_PRE
    ) else $error("precharge phase while disabled");

    chk_auto_recharge: assert property (
        s_drained |=> chargePhase == PH_IDLE ##1 chargePhase != PH_IDLE
    ) else $error("no restart after discharge");

    chk_toggle_restart: assert property (
        s_toggle |=> chargePhase != PH_IDLE
    ) else $error("enable toggle did not restart");

    chk_trickle_entry: assert property (
        $rose(chargePhase == PH_TRICKLE) |-> $past(feedbackLevel < FB_SHORT)
    ) else $error("trickle entered above short threshold");

    chk_timer_stop: assert property (
        timerFault |=> chargePhase == PH_IDLE
    ) else $error("charging with expired safety timer");

endmodule // bccc_charge_ctrl
`default_nettype wire

// ### bccc_charge_ctrl_tb.sv
// self-checking bench for the charge cycle sequencer
// assumes the design answers apb with zero wait states
`timescale 1ns/100ps
`default_nettype none
module bccc_charge_ctrl_tb
    import bccc_pkg::*;
;
    logic             clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic             winOk, hiz, bias, enPin_n, therm, inLim, pinGnd, pinAbove;
    logic             hostAlert, timerFault, regulating, monitor;
    logic [FB_W-1:0]  level, fb;
    logic [LIM_W-1:0] cur, pinLimit, chargeLimit, preLimit, termLimit, target;
    logic [2:0]       chargePhase;
    int               n_mismatch, samples_checked;
    // short safety limit so expiry fits in the run
    localparam int    TMR_LIM = 50;

    bccc_charge_ctrl #(.SAFETY_LIMIT(TMR_LIM)) bccc_charge_ctrl_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .inputWindowOk(winOk), .hizPin(hiz), .biasGood(bias), .chargeEnablePin_n(enPin_n),
        .thermFault(therm), .inputLimitActive(inLim), .feedbackLevel(fb), .chargeCurrent(cur),
        .pinLimit(pinLimit), .pinGrounded(pinGnd), .pinAboveRef(pinAbove),
        .chargePhase(chargePhase), .hostAlert(hostAlert), .timerFault(timerFault),
        .chargeLimit(chargeLimit), .prechargeLimit(preLimit), .termLimit(termLimit),
        .currentTarget(target), .currentRegulating(regulating), .pinMonitorActive(monitor));
    bccc_battery_model bccc_battery_model_inst (
        .level(level), .chargePhase(chargePhase), .currentTarget(target),
        .feedbackLevel(fb), .chargeCurrent(cur));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits for a new phase and checks its alert cycle
    task automatic waitPhase(input logic [2:0] exp);
        for (int i = 0; i < 40 && chargePhase !== exp; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check32(chargePhase, exp);
        check32(hostAlert, 1'b1);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testReset();
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        check32(rd, 32'h0000_00FD);
        apb(1'b0, ADDR_LIMIT, 32'h0000_0000);
        check32(rd, 32'h0000_0190);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        check32({rd[30:0], err}, 32'h0000_0001);
    endtask

    task automatic testCycle();
        @(posedge clk_sys);
        enPin_n <= 1'b0;
        waitPhase(PH_CC);
        @(posedge clk_sys);
        level <= 12'h600;
        waitPhase(PH_CV);
        waitPhase(PH_DONE);
        @(posedge clk_sys);
        enPin_n <= 1'b1;
        waitPhase(PH_IDLE);
        @(posedge clk_sys);
        enPin_n <= 1'b0;
        inLim <= 1'b1;
        waitPhase(PH_CV);
        settle();
        check32(chargePhase, PH_CV);
        @(posedge clk_sys);
        inLim <= 1'b0;
        waitPhase(PH_DONE);
        @(posedge clk_sys);
        level <= 12'h5C8;
        waitPhase(PH_IDLE);
        waitPhase(PH_CC);
    endtask

    task automatic testPre();
        @(posedge clk_sys);
        therm <= 1'b1;
        waitPhase(PH_IDLE);
        @(posedge clk_sys);
        level <= 12'h12C;
        therm <= 1'b0;
        waitPhase(PH_TRICKLE);
        @(posedge clk_sys);
        level <= 12'h320;
        waitPhase(PH_PRE);
        check32(target, 9'h028);
        @(posedge clk_sys);
        hiz <= 1'b1;
        waitPhase(PH_IDLE);
        // supercap setup: precharge, termination, timer off
        apb(1'b1, ADDR_CTRL, 32'h0000_00E1);
        @(posedge clk_sys);
        level <= 12'h12C;
        hiz <= 1'b0;
        waitPhase(PH_CC);
        settle();
        check32(target, 9'h0C8);
    endtask

    task automatic testLimits();
        check32({preLimit, termLimit, chargeLimit}, {9'h028, 9'h014, 9'h0C8});
        apb(1'b1, ADDR_LIMIT, 32'h0000_0064);
        settle();
        check32(chargeLimit, 9'h064);
        apb(1'b1, ADDR_LIMIT, 32'h0000_0002);
        apb(1'b0, ADDR_LIMIT, 32'h0000_0000);
        check32(rd, 32'h0000_0008);
        apb(1'b1, ADDR_LIMIT, 32'h0000_0190);
        @(posedge clk_sys);
        pinAbove <= 1'b1;
        settle();
        check32({regulating, monitor}, 2'b10);
        @(posedge clk_sys);
        pinGnd <= 1'b1;
        settle();
        check32(chargeLimit, 9'h190);
        @(posedge clk_sys);
        pinGnd <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h0000_00DD);
        settle();
        check32({chargeLimit, regulating, monitor}, {9'h190, 2'b00});
    endtask

    // timer under input regulation runs at half rate, then faults
    task automatic testTimer();
        @(posedge clk_sys);
        enPin_n <= 1'b1;
        inLim <= 1'b1;
        waitPhase(PH_IDLE);
        @(posedge clk_sys);
        enPin_n <= 1'b0;
        waitPhase(PH_TRICKLE);
        repeat (2 * TMR_LIM - 1) @(posedge clk_sys);
        #1;
        check32(timerFault, 1'b0);
        @(posedge clk_sys);
        #1;
        check32(timerFault, 1'b1);
        waitPhase(PH_IDLE);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {winOk, bias, enPin_n, hiz, therm, inLim, pinGnd, pinAbove} = 8'b1110_0000;
        level = 12'h4B0;
        pinLimit = 9'h0C8;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        testReset();
        testCycle();
        testPre();
        testLimits();
        testTimer();
        report_and_stop();
    end
endmodule // bccc_charge_ctrl_tb
`default_nettype wire

// ### bccc_pkg.sv
// constants, types and helpers for the charge cycle controller
// assumes a 10 MHz system clock and a 1 mV feedback measurement code
package bccc_pkg;

    // ------------------------------------------------------------
    // clock and safety timer
    // ------------------------------------------------------------
    localparam longint unsigned CLK_HZ        = 64'd10_000_000;
    localparam longint unsigned SAFETY_HOURS  = 64'd12;
    localparam longint unsigned SEC_PER_HOUR  = 64'd3600;
    localparam longint unsigned SAFETY_CYCLES = SAFETY_HOURS * SEC_PER_HOUR * CLK_HZ;
    localparam int              TMR_W         = 41;

    // ------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LIMIT  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // control register fields
    localparam int CTRL_CHG_EN  = 0;
    localparam int CTRL_HIZ     = 1;
    localparam int CTRL_PRE_EN  = 2;
    localparam int CTRL_TERM_EN = 3;
    localparam int CTRL_TMR_EN  = 4;
    localparam int CTRL_PIN_EN  = 5;
    localparam int CTRL_RCH_LO  = 6;
    localparam int CTRL_W       = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'hFD;

    // charge current field: code times 50 mA
    localparam int         LIM_W      = 9;
    localparam logic [8:0] LIM_MIN    = 9'h008;
    localparam logic [8:0] LIM_MAX    = 9'h190;
    localparam logic [6:0] PCT_PRE    = 7'h14;
    localparam logic [6:0] PCT_TERM   = 7'h0A;
    localparam logic [6:0] PCT_FULL   = 7'h64;

    // ------------------------------------------------------------
    // feedback thresholds, mV and permille
    // ------------------------------------------------------------
    localparam int          FB_W       = 12;
    localparam logic [11:0] FB_TARGET  = 12'h600;
    localparam logic [9:0]  PM_LOWV    = 10'h29B;
    localparam logic [9:0]  PM_SHORT   = 10'h12C;
    localparam logic [9:0]  PM_RCH0    = 10'h3A2;
    localparam logic [9:0]  PM_RCH1    = 10'h3AF;
    localparam logic [9:0]  PM_RCH2    = 10'h3B8;
    localparam logic [9:0]  PM_RCH3    = 10'h3D0;
    localparam logic [9:0]  PM_FULL    = 10'h3E8;

    // ------------------------------------------------------------
    // reported phase codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_TRICKLE = 3'b001,
        PH_PRE     = 3'b010,
        PH_CC      = 3'b011,
        PH_CV      = 3'b100,
        PH_DONE    = 3'b111
    } bccc_phase_t;

    function automatic logic [11:0] bccc_fb_pm(input logic [9:0] pm);
        logic [21:0] prod;
        prod = FB_TARGET * pm;
        return 12'(prod / PM_FULL);
    endfunction

    function automatic logic [8:0] bccc_pct(input logic [8:0] v, input logic [6:0] p);
        logic [15:0] prod;
        prod = v * p;
        return 9'(prod / PCT_FULL);
    endfunction

endpackage

// ### bccc_safety_timer.sv
// charge safety timer counting in half steps
// assumes clear, run and halfRate come from the sequencing logic
`timescale 1ns/100ps
`default_nettype none
module bccc_safety_timer
    import bccc_pkg::*;
#(
    parameter longint unsigned LIMIT = SAFETY_CYCLES
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // control
    input  wire logic clear,
    input  wire logic run,
    input  wire logic halfRate,
    // status
    output logic      expired
);

    typedef struct packed {
        logic [TMR_W-1:0] count;
        logic             expired;
    } bccc_tmr_t;

    localparam logic [TMR_W-1:0] END_COUNT = TMR_W'(LIMIT * 2);
    localparam logic [TMR_W-1:0] STEP_FULL = TMR_W'(2);
    localparam logic [TMR_W-1:0] STEP_HALF = TMR_W'(1);

    bccc_tmr_t cur;
    bccc_tmr_t next_cur;

    // ------------------------------------------------------------
    // count, one full step per cycle or half under regulation
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        if (clear) begin
            next_cur.count   = '0;
            next_cur.expired = 1'b0;
        end else if (run && !cur.expired) begin
            next_cur.count = cur.count + (halfRate ? STEP_HALF : STEP_FULL);
            if (next_cur.count >= END_COUNT) begin
                next_cur.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign expired = cur.expired;

endmodule // bccc_safety_timer
`default_nettype wire
